/* rbt_pkg.sv */
/*
 * rbt_pkg: shared constants for the registered bus transceiver.
 * Assumes an APB slave with 32-bit data and word-aligned byte addresses.
 */
package rbt_pkg;

    localparam int unsigned RBT_DATA_W  = 8;
    localparam int unsigned RBT_ADDR_W  = 12;
    localparam int unsigned RBT_SYNC_N  = 2;

    // register byte addresses
    localparam logic [11:0] RBT_CTRL_OFS    = 12'h000;
    localparam logic [11:0] RBT_STORE_A_OFS = 12'h004;
    localparam logic [11:0] RBT_STORE_B_OFS = 12'h008;
    localparam logic [11:0] RBT_STATUS_OFS  = 12'h00C;
    localparam logic [11:0] RBT_LIVE_OFS    = 12'h010;

    // control register fields
    localparam int unsigned RBT_CTRL_DRIVE_EN_N = 0;
    localparam int unsigned RBT_CTRL_DIRECTION  = 1;
    localparam int unsigned RBT_CTRL_A_SRC_SEL  = 2;
    localparam int unsigned RBT_CTRL_B_SRC_SEL  = 3;
    localparam int unsigned RBT_CTRL_W          = 4;

    // drive enable high after reset: both buses isolated
    localparam logic [3:0]  RBT_CTRL_RESET = 4'h1;

    // status register fields
    localparam int unsigned RBT_STAT_A_VALID  = 0;
    localparam int unsigned RBT_STAT_B_VALID  = 1;
    localparam int unsigned RBT_STAT_A_DRIVEN = 2;
    localparam int unsigned RBT_STAT_B_DRIVEN = 3;

    // live register: synced a bus in [7:0], b bus in [15:8]
    localparam int unsigned RBT_LIVE_B_POS = 8;

    localparam logic [31:0] RBT_ZERO_WORD = 32'h0000_0000;

endpackage : rbt_pkg

/* rbt_capture_port.sv */
/*
 * rbt_capture_port: one bus side's input path and storage register.
 * Assumes capture clock and bus data arrive asynchronously on pins;
 * both pass two flip-flops before any logic reads them.
 */
`timescale 1ns/1ps
module rbt_capture_port
    import rbt_pkg::*;
(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // pins
    input  wire logic                  capture_clock_pin,
    input  wire logic [RBT_DATA_W-1:0] bus_pin,
    // to the core
    output logic      [RBT_DATA_W-1:0] live_data,
    output logic      [RBT_DATA_W-1:0] stored_data,
    output logic                       stored_valid
);

    logic                  clk_s1_reg;
    logic                  clk_s2_reg;
    logic                  clk_s3_reg;
    logic [RBT_DATA_W-1:0] bus_s1_reg;
    logic [RBT_DATA_W-1:0] bus_s2_reg;
    logic [RBT_DATA_W-1:0] store_reg;
    logic                  valid_reg;
    wire                   capture_edge;

    // clock and data share latency, so the edge pairs with the data seen then
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_s1_reg <= 1'b0;
            clk_s2_reg <= 1'b0;
            clk_s3_reg <= 1'b0;
            bus_s1_reg <= '0;
            bus_s2_reg <= '0;
        end else begin
            clk_s1_reg <= capture_clock_pin;
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
            bus_s1_reg <= bus_pin;
            bus_s2_reg <= bus_s1_reg;
        end
    end

    assign capture_edge = clk_s2_reg & ~clk_s3_reg;

    // capture regardless of drive state
    // no reset on the storage itself: contents unknown until first edge
    always_ff @(posedge pclk) begin
        if (capture_edge) begin
            store_reg <= bus_s2_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_reg <= 1'b0;
        end else if (capture_edge) begin
            valid_reg <= 1'b1;
        end
    end

    assign live_data    = bus_s2_reg;
    assign stored_data  = store_reg;
    assign stored_valid = valid_reg;

endmodule : rbt_capture_port

/* rbt_transceiver.sv */
/*
 * rbt_transceiver: eight-bit registered bus transceiver between an A bus
 * and a B bus, steered over APB.
 * Assumes bus pins are split into in/out/oe_n by a pad ring or bench, and
 * that the capture clocks are slow against pclk (at least three pclk
 * periods high and low) so every edge is seen.
 */
// Added by the designer: the address map and register access over APB.
// Behaviour
// - rising a-side capture clock stores A bus; b-side clock stores B bus
// - capture happens on every edge whatever enable and direction are
// - enabled: direction low drives A from B, high drives B from A
// - enable high drives neither bus; captures continue, storage holds
// - enabled, direction low, A select low: A bus gets live B data
// - enabled, direction low, A select high: A bus gets stored B data
// - enabled, direction high, B select low: B bus gets live A data
// - enabled, direction high, B select high: B bus gets stored A data
// - the undriven port's value may be captured into either or both
// - at most one bus driven; outside must not drive that bus
`timescale 1ns/1ps
module rbt_transceiver
    import rbt_pkg::*;
(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [RBT_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // capture clock pins
    input  wire logic                  a_side_capture_clock,
    input  wire logic                  b_side_capture_clock,
    // a bus pin
    input  wire logic [RBT_DATA_W-1:0] a_bus_in,
    output logic      [RBT_DATA_W-1:0] a_bus_out,
    output logic                       a_bus_oe_n,
    // b bus pin
    input  wire logic [RBT_DATA_W-1:0] b_bus_in,
    output logic      [RBT_DATA_W-1:0] b_bus_out,
    output logic                       b_bus_oe_n
);

    // per-side input paths and storage
    logic [RBT_DATA_W-1:0] a_live;
    logic [RBT_DATA_W-1:0] b_live;
    logic [RBT_DATA_W-1:0] a_to_b_store;
    logic [RBT_DATA_W-1:0] b_to_a_store;
    logic                  a_store_valid;
    logic                  b_store_valid;

    // each side has its own clock and register, so simultaneous edges
    // store both at once
    rbt_capture_port u_a_side (
        .pclk              (pclk),
        .presetn           (presetn),
        .capture_clock_pin (a_side_capture_clock),
        .bus_pin           (a_bus_in),
        .live_data         (a_live),
        .stored_data       (a_to_b_store),
        .stored_valid      (a_store_valid)
    );

    rbt_capture_port u_b_side (
        .pclk              (pclk),
        .presetn           (presetn),
        .capture_clock_pin (b_side_capture_clock),
        .bus_pin           (b_bus_in),
        .live_data         (b_live),
        .stored_data       (b_to_a_store),
        .stored_valid      (b_store_valid)
    );

    // control register
    logic [RBT_CTRL_W-1:0] ctrl_reg;
    logic [RBT_CTRL_W-1:0] ctrl_next;

    wire drive_enable_n          = ctrl_reg[RBT_CTRL_DRIVE_EN_N];
    wire direction               = ctrl_reg[RBT_CTRL_DIRECTION];
    wire a_output_source_select  = ctrl_reg[RBT_CTRL_A_SRC_SEL];
    wire b_output_source_select  = ctrl_reg[RBT_CTRL_B_SRC_SEL];

    // bus steering
    // one direction bit picks the bus, so both can never be driven
    wire drive_a = ~drive_enable_n & ~direction;
    wire drive_b = ~drive_enable_n &  direction;

    wire [RBT_DATA_W-1:0] a_out_next = a_output_source_select ? b_to_a_store
                                                              : b_live;
    wire [RBT_DATA_W-1:0] b_out_next = b_output_source_select ? a_to_b_store
                                                              : a_live;

    logic [RBT_DATA_W-1:0] a_out_reg;
    logic [RBT_DATA_W-1:0] b_out_reg;
    logic                  a_oe_n_reg;
    logic                  b_oe_n_reg;

    // enables drop on the same edge, so a turnaround never overlaps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_out_reg  <= '0;
            b_out_reg  <= '0;
            a_oe_n_reg <= 1'b1;
            b_oe_n_reg <= 1'b1;
        end else begin
            a_out_reg  <= a_out_next;
            b_out_reg  <= b_out_next;
            a_oe_n_reg <= ~drive_a;
            b_oe_n_reg <= ~drive_b;
        end
    end

    assign a_bus_out  = a_out_reg;
    assign b_bus_out  = b_out_reg;
    assign a_bus_oe_n = a_oe_n_reg;
    assign b_bus_oe_n = b_oe_n_reg;

    // apb decode
    wire apb_setup = psel & ~penable;
    wire apb_write = psel & penable & pwrite;

    wire hit_ctrl    = (paddr == RBT_CTRL_OFS);
    wire hit_store_a = (paddr == RBT_STORE_A_OFS);
    wire hit_store_b = (paddr == RBT_STORE_B_OFS);
    wire hit_status  = (paddr == RBT_STATUS_OFS);
    wire hit_live    = (paddr == RBT_LIVE_OFS);
    wire hit_any     = hit_ctrl | hit_store_a | hit_store_b | hit_status | hit_live;

    // only the control register is writable; writes elsewhere answer error
    wire write_ok    = pwrite ? hit_ctrl : hit_any;

    assign ctrl_next = (apb_write & hit_ctrl) ? pwdata[RBT_CTRL_W-1:0] : ctrl_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= RBT_CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // read mux
    logic [31:0] status_word;
    logic [31:0] live_word;
    logic [31:0] read_word;

    always_comb begin
        status_word = RBT_ZERO_WORD;
        status_word[RBT_STAT_A_VALID]  = a_store_valid;
        status_word[RBT_STAT_B_VALID]  = b_store_valid;
        status_word[RBT_STAT_A_DRIVEN] = ~a_oe_n_reg;
        status_word[RBT_STAT_B_DRIVEN] = ~b_oe_n_reg;
    end

    always_comb begin
        live_word = RBT_ZERO_WORD;
        live_word[RBT_DATA_W-1:0] = a_live;
        live_word[RBT_LIVE_B_POS +: RBT_DATA_W] = b_live;
    end

    always_comb begin
        read_word = RBT_ZERO_WORD;
        if (hit_ctrl) begin
            read_word[RBT_CTRL_W-1:0] = ctrl_reg;
        end else if (hit_store_a) begin
            read_word[RBT_DATA_W-1:0] = a_to_b_store;
        end else if (hit_store_b) begin
            read_word[RBT_DATA_W-1:0] = b_to_a_store;
        end else if (hit_status) begin
            read_word = status_word;
        end else if (hit_live) begin
            read_word = live_word;
        end
    end

    // read data and error are latched in the setup cycle so that they come
    // from flip-flops while pready stays tied high (zero wait states)
    logic [31:0] prdata_reg;
    logic        pslverr_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= RBT_ZERO_WORD;
            pslverr_reg <= 1'b0;
        end else if (apb_setup) begin
            prdata_reg  <= pwrite ? RBT_ZERO_WORD : read_word;
            pslverr_reg <= ~write_ok;
        end
    end

    assign prdata  = prdata_reg;
    assign pslverr = pslverr_reg;
    assign pready  = 1'b1;

endmodule : rbt_transceiver

/* rbt_bus_model.sv */
/* rbt_bus_model: far-side logic on the A and B buses.
   Assumes the bench supplies the values it puts on each bus. */
`timescale 1ns/1ps
module rbt_bus_model
    import rbt_pkg::*;
(
    // far-side values
    input  wire logic [RBT_DATA_W-1:0] a_drive,
    input  wire logic [RBT_DATA_W-1:0] b_drive,
    // device side
    input  wire logic [RBT_DATA_W-1:0] a_bus_out,
    input  wire logic [RBT_DATA_W-1:0] b_bus_out,
    input  wire logic                  a_bus_oe_n,
    input  wire logic                  b_bus_oe_n,
    // resolved wires
    output logic      [RBT_DATA_W-1:0] a_bus_in,
    output logic      [RBT_DATA_W-1:0] b_bus_in
);
    // let go of a bus the device drives, so no contention
    assign a_bus_in = a_bus_oe_n ? a_drive : a_bus_out;
    assign b_bus_in = b_bus_oe_n ? b_drive : b_bus_out;
endmodule : rbt_bus_model

/* rbt_transceiver_monitor.sv */
/* rbt_transceiver_monitor: port checks for the transceiver.
   Assumes it is bound to rbt_transceiver and sees its ports only. */
`timescale 1ns/1ps
module rbt_transceiver_monitor
    import rbt_pkg::*;
(
    // clock, reset, apb
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [RBT_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    // pins
    input  wire logic                  a_side_capture_clock,
    input  wire logic                  b_side_capture_clock,
    input  wire logic [RBT_DATA_W-1:0] a_bus_in,
    input  wire logic [RBT_DATA_W-1:0] b_bus_in,
    input  wire logic [RBT_DATA_W-1:0] a_bus_out,
    input  wire logic [RBT_DATA_W-1:0] b_bus_out,
    input  wire logic                  a_bus_oe_n,
    input  wire logic                  b_bus_oe_n
);
    logic [3:0] ctrl_reg;
    wire        ctrl_wr  = psel && penable && pwrite && paddr == RBT_CTRL_OFS;
    wire        en       = !ctrl_reg[0];
    wire        a_live   = en && !ctrl_reg[1] && !ctrl_reg[2];
    wire        a_stored = en && !ctrl_reg[1] && ctrl_reg[2];
    wire        b_live   = en && ctrl_reg[1] && !ctrl_reg[3];
    wire        b_stored = en && ctrl_reg[1] && ctrl_reg[3];
    // shadow of control, rebuilt from apb writes seen at the ports
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= RBT_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_reg <= pwdata[3:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_a_live; (a_live && $stable(b_bus_in)) [*4]; endsequence
    sequence s_b_live; (b_live && $stable(a_bus_in)) [*4]; endsequence
    sequence s_a_hold; (a_stored && !$rose(b_side_capture_clock)) [*6]; endsequence
    sequence s_b_hold; (b_stored && !$rose(a_side_capture_clock)) [*6]; endsequence
    property p_one_driver; a_bus_oe_n || b_bus_oe_n; endproperty
    a_one_driver: assert property (p_one_driver) else $error("both buses driven");
    property p_isolate; ctrl_reg[0] |=> a_bus_oe_n && b_bus_oe_n; endproperty
    a_isolate: assert property (p_isolate) else $error("bus driven while disabled");
    property p_drive_a; en && !ctrl_reg[1] |=> !a_bus_oe_n && b_bus_oe_n; endproperty
    a_drive_a: assert property (p_drive_a) else $error("a bus not driven");
    property p_drive_b; en && ctrl_reg[1] |=> a_bus_oe_n && !b_bus_oe_n; endproperty
    a_drive_b: assert property (p_drive_b) else $error("b bus not driven");
    property p_live_a; s_a_live |=> a_bus_out == $past(b_bus_in); endproperty
    a_live_a: assert property (p_live_a) else $error("a bus not live b");
    property p_live_b; s_b_live |=> b_bus_out == $past(a_bus_in); endproperty
    a_live_b: assert property (p_live_b) else $error("b bus not live a");
    property p_store_a; s_a_hold |=> $stable(a_bus_out); endproperty
    a_store_a: assert property (p_store_a) else $error("stored b moved");
    property p_store_b; s_b_hold |=> $stable(b_bus_out); endproperty
    a_store_b: assert property (p_store_b) else $error("stored a moved");
endmodule : rbt_transceiver_monitor

bind rbt_transceiver rbt_transceiver_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .a_side_capture_clock, .b_side_capture_clock, .a_bus_in, .b_bus_in, .a_bus_out, .b_bus_out,
    .a_bus_oe_n, .b_bus_oe_n);

/* tb.sv */
/* tb: self-checking bench for rbt_transceiver.
   Assumes the bus model resolves both buses and the monitor is bound. */
`timescale 1ns/1ps
module tb
    import rbt_pkg::*;
;
    logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic                  a_side_capture_clock, b_side_capture_clock, a_bus_oe_n, b_bus_oe_n;
    logic [RBT_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata, prdata, rd;
    logic [RBT_DATA_W-1:0] a_drive, b_drive, a_bus_in, b_bus_in, a_bus_out, b_bus_out;
    int                    n_errors = 0;
    int                    n_tests  = 0;
    rbt_transceiver u_rbt_transceiver (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .a_side_capture_clock, .b_side_capture_clock, .a_bus_in, .a_bus_out, .a_bus_oe_n,
        .b_bus_in, .b_bus_out, .b_bus_oe_n);
    rbt_bus_model u_rbt_bus_model (.a_drive, .b_drive, .a_bus_out, .b_bus_out, .a_bus_oe_n, .b_bus_oe_n,
        .a_bus_in, .b_bus_in);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // a wait that runs out counts against the run
        if (pready !== 1'b1) n_errors++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never reassigns psel in this time step
        @(posedge pclk);
    endtask : apb
    task automatic rchk(input logic [11:0] ad, input logic [31:0] exp, input logic exp_er);
        apb(1'b0, ad, 32'h0000_0000);
        check(rd, exp);
        check(32'(er), 32'(exp_er));
    endtask : rchk
    // data held well before and after each edge, clock high and low 4 cycles
    task automatic pulse(input logic do_a, input logic do_b);
        repeat (4) @(posedge pclk);
        a_side_capture_clock <= do_a;
        b_side_capture_clock <= do_b;
        repeat (4) @(posedge pclk);
        a_side_capture_clock <= 1'b0;
        b_side_capture_clock <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : pulse
    task automatic t_isolation;
        rchk(RBT_CTRL_OFS, 32'h0000_0001, 1'b0);
        rchk(RBT_STATUS_OFS, 32'h0000_0000, 1'b0);
        a_drive <= 8'h5A;
        b_drive <= 8'hA5;
        pulse(1'b1, 1'b1);
        apb(1'b1, RBT_STORE_A_OFS, 32'h0000_00FF);
        check(32'(er), 32'h0000_0001);
        rchk(RBT_STORE_A_OFS, 32'h0000_005A, 1'b0);
        rchk(RBT_STORE_B_OFS, 32'h0000_00A5, 1'b0);
        rchk(RBT_STATUS_OFS, 32'h0000_0003, 1'b0);
        rchk(RBT_LIVE_OFS, 32'h0000_A55A, 1'b0);
        rchk(12'h020, 32'h0000_0000, 1'b1);
        check(32'({a_bus_oe_n, b_bus_oe_n}), 32'h0000_0003);
    endtask : t_isolation
    task automatic t_modes;
        logic [3:0] ctl;
        logic [7:0] exp;
        a_drive <= 8'h3C;
        b_drive <= 8'hC3;
        for (int i = 0; i < 4; i++) begin
            ctl = i[1] ? {i[0], 3'b010} : {1'b0, i[0], 2'b00};
            exp = i[1] ? (i[0] ? 8'h5A : 8'h3C) : (i[0] ? 8'hA5 : 8'hC3);
            apb(1'b1, RBT_CTRL_OFS, 32'(ctl));
            repeat (5) @(posedge pclk);
            check(32'(i[1] ? b_bus_out : a_bus_out), 32'(exp));
            check(32'({a_bus_oe_n, b_bus_oe_n}), 32'(i[1] ? 2'b10 : 2'b01));
        end
        // both stored, only B driven
        rchk(RBT_STATUS_OFS, 32'h0000_000B, 1'b0);
        // a is an input while b shows stored a, so a new capture reaches b
        a_drive <= 8'h77;
        pulse(1'b1, 1'b0);
        check(32'(b_bus_out), 32'h0000_0077);
    endtask : t_modes
    // mid-run reset isolates both buses but leaves storage untouched
    task automatic t_reset;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check(32'({a_bus_oe_n, b_bus_oe_n}), 32'h0000_0003);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(RBT_CTRL_OFS, 32'h0000_0001, 1'b0);
        rchk(RBT_STATUS_OFS, 32'h0000_0000, 1'b0);
        rchk(RBT_STORE_A_OFS, 32'h0000_0077, 1'b0);
        rchk(RBT_STORE_B_OFS, 32'h0000_00A5, 1'b0);
    endtask : t_reset
    task automatic complete_run;
        if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, a_side_capture_clock, b_side_capture_clock} = 6'h00;
        {paddr, pwdata, a_drive, b_drive} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_isolation;
        t_modes;
        t_reset;
        complete_run;
    end
    // tests need about 111 cycles
    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        complete_run;
    end
endmodule : tb
